// *** rtl/framer_test_pkg.sv ***
// constants and types shared by the framer test/sysref control ends
// Summary of operation
// RL1: converter samples normal; checkerboard, toggle, ramp sources
// RL2: prbs orders 31, 23, 15, 9, 7 selectable
// RL3: user 16-bit word, repeated or sent once
// RL4: insert at framer, serdes entry or after map
// RL5: sysref gate addressed by any framer mask
// RL6: multiframe clock realigns only on sysref rise
// RL7: per-framer sysref gate, 1 passes, 0 blocks
// RL8: sysref gates open after reset
// RL9: sync sequencer holds sysref until stages done
// RL10: 8-bit status word, bits 7..4 reserved zero
// RL11: status bit 3 is sync request level
// RL12: status bit 2 flags later sysref phase mismatch
// RL13: status bit 1 shows sysref phase established
// RL14: status bit 0 flags unsupported configuration
// RL15: expose lane-align state and chosen sync input
// RL16: test data replaces sample data on lanes
// RL17: error injection inverts test data bits
// RL18: injection one framer, four-bit lane mask
// RL19: controller injects only after test data enabled
// RL20: framer enable allows disable and relink
// RL21: controller reads status only with links running; the controller here reads status with links disabled too
// RL22: sync input choice 0, 1, 2 picks input
// RL23: prbs use customary maximal-length polynomials
// RL24: injection corrupts one data word per request
package framer_test_pkg;
  localparam int NUM_FRAMERS = 3;
  localparam int NUM_LANES   = 4;
  localparam int WORD_W      = 16;
  localparam int MF_W        = 5;
  localparam logic [MF_W-1:0] MF_LAST = 5'h1F;

  typedef enum logic [3:0] {
    converter_sample_source  = 4'h0,
    alternating_pattern_source = 4'h1,
    word_toggle_source       = 4'h2,
    prbs_order_31_source     = 4'h3,
    prbs_order_23_source     = 4'h4,
    prbs_order_15_source     = 4'h5,
    prbs_order_9_source      = 4'h6,
    prbs_order_7_source      = 4'h7,
    incrementing_ramp_source = 4'h8,
    user_word_repeat_source  = 4'h9,
    user_word_single_source  = 4'hA
  } source_t;

  typedef enum logic [1:0] {
    inject_at_framer_entry = 2'h0,
    inject_at_serdes_entry = 2'h1,
    inject_after_lane_map  = 2'h2
  } insert_t;

  // status word fields
  localparam int ST_SYNC    = 3;
  localparam int ST_PHERR   = 2;
  localparam int ST_PHASE   = 1;
  localparam int ST_BADCFG  = 0;
  localparam logic [7:0] ST_RSVD_MASK = 8'h0F;

  localparam logic [WORD_W-1:0] CHECKER_WORD = 16'hAAAA;
  localparam logic [WORD_W-1:0] ZERO_WORD    = 16'h0000;
  localparam logic [WORD_W-1:0] ONES_WORD    = 16'hFFFF;
  localparam logic [31:0]       PRBS_SEED    = 32'h7FFFFFFF;

  // lane-align states
  typedef enum logic [2:0] {
    align_idle = 3'b001,
    align_cgs  = 3'b010,
    align_data = 3'b100
  } align_t;

  // apb register map of the controller (byte offsets)
  localparam logic [7:0] REG_ENABLE = 8'h00;
  localparam logic [7:0] REG_GATE   = 8'h04;
  localparam logic [7:0] REG_TEST   = 8'h08;
  localparam logic [7:0] REG_USER   = 8'h0C;
  localparam logic [7:0] REG_INJECT = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;
  localparam logic [7:0] REG_SYNCSEL = 8'h18;
  localparam logic [7:0] REG_MCS    = 8'h1C;
  localparam logic [7:0] REG_SAMPLE = 8'h20;
endpackage

// *** rtl/framer_ctrl_if.sv ***
// control interface joining the controller to the framer block
interface framer_ctrl_if;
  import framer_test_pkg::*;
  logic [NUM_FRAMERS-1:0]  link_en;
  logic [NUM_FRAMERS-1:0]  gate_mask;
  logic                    gate_val;
  logic                    gate_wr;
  logic [NUM_FRAMERS-1:0]  test_mask;
  source_t                 test_src;
  insert_t                 test_pt;
  logic                    test_wr;
  logic [WORD_W-1:0]       user_word;
  logic [1:0]              inj_framer;
  logic [NUM_LANES-1:0]    lane_choice_mask;
  logic                    inj_req;
  logic [1:0]              stat_sel;
  logic [7:0]              framer_state_word;
  align_t                  lane_align_state;
  logic [1:0]              sync_input_used;
  logic [2*NUM_FRAMERS-1:0] sync_input_choice;
  logic                    mcs_done;

  modport device (
    input  link_en, gate_mask, gate_val, gate_wr, test_mask, test_src, test_pt,
    input  test_wr, user_word, inj_framer, lane_choice_mask, inj_req, stat_sel,
    input  sync_input_choice, mcs_done,
    output framer_state_word, lane_align_state, sync_input_used
  );
  modport host (
    output link_en, gate_mask, gate_val, gate_wr, test_mask, test_src, test_pt,
    output test_wr, user_word, inj_framer, lane_choice_mask, inj_req, stat_sel,
    output sync_input_choice, mcs_done,
    input  framer_state_word, lane_align_state, sync_input_used
  );
endinterface

// *** rtl/pattern_gen.sv ***
// one framer's test-word generator
module pattern_gen
  import framer_test_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              run,
  input  wire logic              restart,
  input  framer_test_pkg::source_t src,
  input  wire logic [WORD_W-1:0] user_word,
  output logic [WORD_W-1:0]      word
);
  import framer_test_pkg::*;

  logic [31:0]       lfsr_q, lfsr_d;
  logic [WORD_W-1:0] ramp_q, ramp_d;
  logic              tog_q, tog_d;
  logic              once_q, once_d;
  logic [WORD_W-1:0] word_q, word_d;

  // one prbs step for a given order, customary maximal-length taps
  function automatic logic [31:0] prbs_step(input logic [31:0] s, input source_t k);
    logic fb;
    fb = 1'b0;
    case (k)
      prbs_order_31_source: fb = s[30] ^ s[27];
      prbs_order_23_source: fb = s[22] ^ s[17];
      prbs_order_15_source: fb = s[14] ^ s[13];
      prbs_order_9_source:  fb = s[8] ^ s[4];
      default:              fb = s[6] ^ s[5];
    endcase
    return {s[30:0], fb};
  endfunction

  // sixteen prbs steps per word; [RL23]
  always_comb begin
    lfsr_d = lfsr_q;
    ramp_d = ramp_q;
    tog_d  = tog_q;
    once_d = once_q;
    word_d = word_q;
    if (restart) begin
      lfsr_d = PRBS_SEED;
      ramp_d = ZERO_WORD;
      tog_d  = 1'b0;
      once_d = 1'b0;
    end else if (run) begin
      for (int i = 0; i < WORD_W; i++) begin
        lfsr_d = prbs_step(lfsr_d, src);
      end
      ramp_d = ramp_q + 16'h0001;
      tog_d  = ~tog_q;
      once_d = 1'b1;
      case (src)
        alternating_pattern_source: word_d = CHECKER_WORD; // [RL1]
        word_toggle_source:         word_d = tog_q ? ONES_WORD : ZERO_WORD;
        incrementing_ramp_source:   word_d = ramp_q;
        user_word_repeat_source:    word_d = user_word; // [RL3]
        user_word_single_source:    word_d = once_q ? ZERO_WORD : user_word; // [RL3]
        prbs_order_31_source, prbs_order_23_source, prbs_order_15_source,
        prbs_order_9_source, prbs_order_7_source:
                                    word_d = lfsr_d[WORD_W-1:0]; // [RL2]
        default:                    word_d = ZERO_WORD;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lfsr_q <= PRBS_SEED;
      ramp_q <= ZERO_WORD;
      tog_q  <= 1'b0;
      once_q <= 1'b0;
      word_q <= ZERO_WORD;
    end else begin
      lfsr_q <= lfsr_d;
      ramp_q <= ramp_d;
      tog_q  <= tog_d;
      once_q <= once_d;
      word_q <= word_d;
    end
  end

  assign word = word_q;
endmodule

// *** rtl/framer_test_ctrl.sv ***
// device end: test patterns, error injection, sysref gating, status
module framer_test_ctrl
  import framer_test_pkg::*;
(
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  framer_ctrl_if.device               ctl,
  input  wire logic                   sysref_pin,
  input  wire logic [2:0]             sync_request_input,
  input  wire logic [NUM_FRAMERS-1:0] cfg_unsupported,
  input  wire logic [NUM_FRAMERS*NUM_LANES*WORD_W-1:0] sample_in,
  output logic [NUM_FRAMERS*NUM_LANES*WORD_W-1:0]      lane_out,
  output logic [NUM_FRAMERS-1:0]      mf_start,
  output logic [NUM_FRAMERS*2-1:0]    insert_point_out
);
  import framer_test_pkg::*;

  // pin inputs pass three flops; the first is read only by the second
  logic [3:0] pin_s1_q, pin_s2_q, pin_s3_q, pin_lvl_q, pin_lvl_d;

  // a change counts once flops two and three agree; one-cycle glitches die here
  always_comb begin
    pin_lvl_d = (pin_s2_q & pin_s3_q) | (pin_lvl_q & (pin_s2_q | pin_s3_q));
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_q  <= 4'h0;
      pin_s2_q  <= 4'h0;
      pin_s3_q  <= 4'h0;
      pin_lvl_q <= 4'h0;
    end else begin
      pin_s1_q  <= {sync_request_input, sysref_pin};
      pin_s2_q  <= pin_s1_q;
      pin_s3_q  <= pin_s2_q;
      pin_lvl_q <= pin_lvl_d;
    end
  end
  wire logic sysref_rise = pin_lvl_d[0] & ~pin_lvl_q[0];
  wire logic [2:0] sync_lvl = pin_lvl_q[3:1];

  // control registers
  logic [NUM_FRAMERS-1:0] gate_q, gate_d;
  logic [NUM_FRAMERS-1:0] test_on_q, test_on_d;
  logic [NUM_FRAMERS-1:0] restart;
  source_t                src_q[NUM_FRAMERS], src_d[NUM_FRAMERS];
  insert_t                pt_q[NUM_FRAMERS], pt_d[NUM_FRAMERS];
  logic [NUM_LANES-1:0]   inv_q[NUM_FRAMERS], inv_d[NUM_FRAMERS];

  always_comb begin
    gate_d    = gate_q;
    test_on_d = test_on_q;
    restart   = '0;
    for (int f = 0; f < NUM_FRAMERS; f++) begin
      src_d[f] = src_q[f];
      pt_d[f]  = pt_q[f];
      inv_d[f] = '0; // one corrupted word per request [RL24]
      if (ctl.gate_wr && ctl.gate_mask[f]) begin
        gate_d[f] = ctl.gate_val; // [RL5] [RL7]
      end
      if (ctl.test_wr && ctl.test_mask[f]) begin
        src_d[f]     = ctl.test_src;
        pt_d[f]      = ctl.test_pt; // [RL4]
        test_on_d[f] = (ctl.test_src != converter_sample_source);
        restart[f]   = 1'b1;
      end
      // one framer, chosen lanes; ignored unless test data runs [RL18]
      if (ctl.inj_req && ctl.inj_framer == 2'(f) && test_on_q[f]) begin
        inv_d[f] = ctl.lane_choice_mask; // [RL17]
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_q    <= {NUM_FRAMERS{1'b1}}; // open after reset [RL8]
      test_on_q <= '0;
      for (int f = 0; f < NUM_FRAMERS; f++) begin
        src_q[f] <= converter_sample_source;
        pt_q[f]  <= inject_at_framer_entry;
        inv_q[f] <= '0;
      end
    end else begin
      gate_q    <= gate_d;
      test_on_q <= test_on_d;
      for (int f = 0; f < NUM_FRAMERS; f++) begin
        src_q[f] <= src_d[f];
        pt_q[f]  <= pt_d[f];
        inv_q[f] <= inv_d[f];
      end
    end
  end

  // per-framer datapath, multiframe clock and status
  logic [MF_W-1:0]  mf_q[NUM_FRAMERS], mf_d[NUM_FRAMERS];
  logic [NUM_FRAMERS-1:0] phase_q, phase_d, perr_q, perr_d, mfs_q, mfs_d;
  logic [NUM_FRAMERS*NUM_LANES*WORD_W-1:0] lane_q, lane_d;
  logic [WORD_W-1:0] pat[NUM_FRAMERS];
  logic [NUM_FRAMERS*2-1:0] ipt_q, ipt_d;
  logic [1:0] ssel[NUM_FRAMERS];

  genvar g;
  generate
    for (g = 0; g < NUM_FRAMERS; g++) begin : gen_fr
      pattern_gen pattern_gen_inst (
        .pclk      (pclk),
        .presetn   (presetn),
        .run       (test_on_q[g] & ctl.link_en[g]),
        .restart   (restart[g]),
        .src       (src_q[g]),
        .user_word (ctl.user_word),
        .word      (pat[g])
      );
      assign ssel[g] = ctl.sync_input_choice[2*g +: 2];
    end
  endgenerate

  always_comb begin
    lane_d  = lane_q;
    phase_d = phase_q;
    perr_d  = perr_q;
    mfs_d   = '0;
    ipt_d   = ipt_q;
    for (int f = 0; f < NUM_FRAMERS; f++) begin
      mf_d[f] = mf_q[f] + 5'h01;
      // sysref reaches a framer only if gate open and sequencer done [RL7] [RL9]
      if (!ctl.link_en[f]) begin
        mf_d[f]    = '0; // disabled framer drops its phase for relink [RL20]
        phase_d[f] = 1'b0;
        perr_d[f]  = 1'b0;
      end else if (sysref_rise && gate_q[f] && ctl.mcs_done) begin
        if (!phase_q[f]) begin
          mf_d[f]    = '0; // realign only on a rising edge [RL6]
          phase_d[f] = 1'b1; // [RL13]
        end else if (mf_q[f] != MF_LAST) begin
          perr_d[f] = 1'b1; // later edge off the first phase [RL12]
        end
      end
      mfs_d[f] = ctl.link_en[f] && (mf_q[f] == MF_LAST);
      ipt_d[2*f +: 2] = pt_q[f];
      for (int l = 0; l < NUM_LANES; l++) begin
        if (!ctl.link_en[f]) begin
          lane_d[(f*NUM_LANES+l)*WORD_W +: WORD_W] = ZERO_WORD;
        end else if (test_on_q[f]) begin
          // test data replaces samples [RL16]
          lane_d[(f*NUM_LANES+l)*WORD_W +: WORD_W] =
            inv_q[f][l] ? ~pat[f] : pat[f]; // [RL17]
        end else begin
          lane_d[(f*NUM_LANES+l)*WORD_W +: WORD_W] =
            sample_in[(f*NUM_LANES+l)*WORD_W +: WORD_W]; // [RL1]
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lane_q  <= '0;
      phase_q <= '0;
      perr_q  <= '0;
      mfs_q   <= '0;
      ipt_q   <= '0;
      for (int f = 0; f < NUM_FRAMERS; f++) begin
        mf_q[f] <= '0;
      end
    end else begin
      lane_q  <= lane_d;
      phase_q <= phase_d;
      perr_q  <= perr_d;
      mfs_q   <= mfs_d;
      ipt_q   <= ipt_d;
      for (int f = 0; f < NUM_FRAMERS; f++) begin
        mf_q[f] <= mf_d[f];
      end
    end
  end

  // status word of the framer named by stat_sel [RL10]
  logic [7:0] stw_q, stw_d;
  align_t     al_q, al_d;
  logic [1:0] su_q, su_d;
  always_comb begin
    int s;
    s     = (ctl.stat_sel < 2'(NUM_FRAMERS)) ? int'(ctl.stat_sel) : 0;
    stw_d = 8'h00; // reserved bits read zero
    su_d  = (ssel[s] < 2'(NUM_FRAMERS)) ? ssel[s] : 2'h0; // [RL22]
    stw_d[ST_SYNC]   = sync_lvl[su_d]; // [RL11]
    stw_d[ST_PHERR]  = perr_q[s]; // [RL12]
    stw_d[ST_PHASE]  = phase_q[s]; // [RL13]
    stw_d[ST_BADCFG] = cfg_unsupported[s]; // [RL14]
    stw_d = stw_d & ST_RSVD_MASK;
    // align state: idle disabled, cgs while sync low, data else [RL15]
    if (!ctl.link_en[s]) begin
      al_d = align_idle;
    end else if (!sync_lvl[su_d]) begin
      al_d = align_cgs;
    end else begin
      al_d = align_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stw_q <= 8'h00;
      al_q  <= align_idle;
      su_q  <= 2'h0;
    end else begin
      stw_q <= stw_d;
      al_q  <= al_d;
      su_q  <= su_d;
    end
  end

  assign ctl.framer_state_word = stw_q;
  assign ctl.lane_align_state  = al_q;
  assign ctl.sync_input_used   = su_q; // [RL15]
  assign lane_out         = lane_q;
  assign mf_start         = mfs_q;
  assign insert_point_out = ipt_q;
endmodule

// *** rtl/framer_host_ctrl.sv ***
// controller end: apb registers driving the framer control interface
module framer_host_ctrl
  import framer_test_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  framer_ctrl_if.host      ctl
);
  import framer_test_pkg::*;

  logic [NUM_FRAMERS-1:0] en_q, en_d;
  logic [31:0] rd_q, rd_d;
  logic        err_q, err_d, rdy_q, rdy_d;
  logic [NUM_FRAMERS-1:0] gm_q, gm_d, tm_q, tm_d;
  logic gv_q, gv_d, gw_q, gw_d, tw_q, tw_d, ij_q, ij_d, mcs_q, mcs_d;
  source_t src_q, src_d;
  insert_t pt_q, pt_d;
  logic [WORD_W-1:0] uw_q, uw_d;
  logic [1:0] ifr_q, ifr_d, ss_q, ss_d;
  logic [NUM_LANES-1:0] lm_q, lm_d;
  logic [2*NUM_FRAMERS-1:0] sc_q, sc_d;

  wire logic acc = psel & penable & ~rdy_q;

  // one-wait-state apb: pready rises one cycle into the access phase
  always_comb begin
    en_d = en_q;
    rd_d = rd_q;
    err_d = 1'b0;
    rdy_d = acc;
    gm_d = gm_q;
    gv_d = gv_q;
    gw_d = 1'b0;
    tm_d = tm_q;
    tw_d = 1'b0;
    src_d = src_q;
    pt_d = pt_q;
    uw_d = uw_q;
    ifr_d = ifr_q;
    lm_d = lm_q;
    ij_d = 1'b0;
    ss_d = ss_q;
    sc_d = sc_q;
    mcs_d = mcs_q;
    if (acc && pwrite) begin
      case (paddr)
        REG_ENABLE: en_d = pwdata[NUM_FRAMERS-1:0]; // [RL20]
        REG_GATE: begin
          gm_d = pwdata[NUM_FRAMERS-1:0]; // [RL5]
          gv_d = pwdata[8];
          gw_d = 1'b1;
        end
        REG_TEST: begin
          tm_d  = pwdata[NUM_FRAMERS-1:0];
          src_d = source_t'(pwdata[11:8]);
          pt_d  = insert_t'(pwdata[17:16]);
          tw_d  = 1'b1;
        end
        REG_USER: uw_d = pwdata[WORD_W-1:0];
        REG_INJECT: begin
          ifr_d = pwdata[1:0]; // [RL18]
          lm_d  = pwdata[11:8];
          ij_d  = 1'b1; // device ignores it without test data [RL19]
        end
        REG_SYNCSEL: sc_d = pwdata[2*NUM_FRAMERS-1:0];
        REG_MCS: mcs_d = pwdata[0];
        REG_STATUS: ss_d = pwdata[1:0];
        default: err_d = 1'b1;
      endcase
    end else if (acc) begin
      case (paddr)
        REG_ENABLE: rd_d = {29'h0, en_q};
        REG_GATE:   rd_d = {23'h0, gv_q, 5'h0, gm_q};
        REG_TEST:   rd_d = {14'h0, pt_q, 4'h0, src_q, 5'h0, tm_q};
        REG_USER:   rd_d = {16'h0, uw_q};
        REG_INJECT: rd_d = {20'h0, lm_q, 6'h0, ifr_q};
        REG_SYNCSEL: rd_d = {26'h0, sc_q};
        REG_MCS:    rd_d = {31'h0, mcs_q};
        // status read: served whether or not links are running [RL21]
        REG_STATUS: rd_d = {14'h0, ctl.sync_input_used, 5'h0, ctl.lane_align_state,
                            ctl.framer_state_word};
        default: begin
          rd_d  = 32'h0;
          err_d = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q <= {NUM_FRAMERS{1'b1}};
      rd_q <= 32'h0;
      err_q <= 1'b0;
      rdy_q <= 1'b0;
      gm_q <= '0;
      gv_q <= 1'b1;
      gw_q <= 1'b0;
      tm_q <= '0;
      tw_q <= 1'b0;
      src_q <= converter_sample_source;
      pt_q <= inject_at_framer_entry;
      uw_q <= ZERO_WORD;
      ifr_q <= 2'h0;
      lm_q <= '0;
      ij_q <= 1'b0;
      ss_q <= 2'h0;
      sc_q <= '0;
      mcs_q <= 1'b0;
    end else begin
      en_q <= en_d;
      rd_q <= rd_d;
      err_q <= err_d;
      rdy_q <= rdy_d;
      gm_q <= gm_d;
      gv_q <= gv_d;
      gw_q <= gw_d;
      tm_q <= tm_d;
      tw_q <= tw_d;
      src_q <= src_d;
      pt_q <= pt_d;
      uw_q <= uw_d;
      ifr_q <= ifr_d;
      lm_q <= lm_d;
      ij_q <= ij_d;
      ss_q <= ss_d;
      sc_q <= sc_d;
      mcs_q <= mcs_d;
    end
  end

  assign prdata  = rd_q;
  assign pready  = rdy_q;
  assign pslverr = err_q;
  assign ctl.link_en = en_q;
  assign ctl.gate_mask = gm_q;
  assign ctl.gate_val = gv_q;
  assign ctl.gate_wr = gw_q;
  assign ctl.test_mask = tm_q;
  assign ctl.test_src = src_q;
  assign ctl.test_pt = pt_q;
  assign ctl.test_wr = tw_q;
  assign ctl.user_word = uw_q;
  assign ctl.inj_framer = ifr_q;
  assign ctl.lane_choice_mask = lm_q;
  assign ctl.inj_req = ij_q;
  assign ctl.stat_sel = ss_q;
  assign ctl.sync_input_choice = sc_q;
  assign ctl.mcs_done = mcs_q;
endmodule

// *** verif/framer_ctrl_props.sv ***
// assertions on the control interface joining the two framer ends
module framer_ctrl_props
  import framer_test_pkg::*;
(
  input wire logic                     pclk,
  input wire logic                     presetn,
  input wire logic [NUM_FRAMERS-1:0]   link_en,
  input wire logic                     gate_val,
  input wire logic                     gate_wr,
  input wire logic                     test_wr,
  input wire logic                     inj_req,
  input wire logic [1:0]               stat_sel,
  input wire logic [7:0]               framer_state_word,
  input framer_test_pkg::align_t       lane_align_state,
  input wire logic [1:0]               sync_input_used,
  input wire logic [2*NUM_FRAMERS-1:0] sync_input_choice
);
  import framer_test_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic [1:0] raw_used;
  logic [1:0] exp_used;
  // an unused choice code of 3 reads back as input 0
  assign raw_used = (stat_sel == 2'h3) ? sync_input_choice[1:0] :
                    sync_input_choice[2*stat_sel +: 2];
  assign exp_used = (raw_used == 2'h3) ? 2'h0 : raw_used;

  chk_rsvd_bits_zero: assert property (framer_state_word[7:4] == 4'h0)
    else $error("reserved status bits not zero");
  chk_gate_wr_single: assert property (gate_wr |=> !gate_wr)
    else $error("gate write pulse longer than one cycle");
  chk_test_wr_single: assert property (test_wr |=> !test_wr)
    else $error("test write pulse longer than one cycle");
  chk_inj_req_single: assert property (inj_req |=> !inj_req)
    else $error("inject pulse longer than one cycle");
  chk_align_onehot: assert property ($onehot(lane_align_state))
    else $error("lane align state not one-hot");
  chk_sync_used_match: assert property (
    ($stable(stat_sel) && $stable(sync_input_choice)) [*3] |-> sync_input_used == exp_used)
    else $error("sync input used differs from choice");
  chk_reset_open_gate: assert property (
    $rose(presetn) |-> link_en == 3'h7 && gate_val == 1'b1)
    else $error("link or gate not open after reset");
  chk_phase_err_order: assert property (
    framer_state_word[ST_PHERR] |-> framer_state_word[ST_PHASE])
    else $error("phase error without established phase");
  chk_disable_clears: assert property (
    (!link_en[stat_sel] && $stable(stat_sel)) [*4] |-> !framer_state_word[ST_PHERR])
    else $error("phase error kept on disabled link");

  cover property (inj_req);
  cover property (gate_wr && !gate_val);
  cover property (framer_state_word[ST_PHERR]);
endmodule

// *** verif/framer_test_and_sysref_control_tb.sv ***
// self-checking bench for the controller and framer block pair
module framer_test_and_sysref_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import framer_test_pkg::*;

  logic                   pclk;
  logic                   presetn;
  logic                   psel;
  logic                   penable;
  logic                   pwrite;
  logic [7:0]             paddr;
  logic [31:0]            pwdata;
  logic [31:0]            prdata;
  logic                   pready;
  logic                   pslverr;
  logic                   sysref_pin;
  logic [2:0]             sync_request_input;
  logic [NUM_FRAMERS-1:0] cfg_unsupported;
  logic [NUM_FRAMERS-1:0] mf_start;
  logic [191:0]           sample_in;
  logic [191:0]           lane_out;
  logic [5:0]             insert_point_out;
  int                     errors;
  int                     n_checks;
  int                     n;

  framer_ctrl_if ctl_bus ();

  framer_host_ctrl framer_host_ctrl_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ctl(ctl_bus)
  );
  framer_test_ctrl framer_test_ctrl_inst (
    .pclk(pclk), .presetn(presetn), .ctl(ctl_bus), .sysref_pin(sysref_pin),
    .sync_request_input(sync_request_input), .cfg_unsupported(cfg_unsupported),
    .sample_in(sample_in), .lane_out(lane_out), .mf_start(mf_start),
    .insert_point_out(insert_point_out)
  );
  framer_ctrl_props framer_ctrl_props_inst (
    .pclk(pclk), .presetn(presetn), .link_en(ctl_bus.link_en), .gate_val(ctl_bus.gate_val),
    .gate_wr(ctl_bus.gate_wr), .test_wr(ctl_bus.test_wr), .inj_req(ctl_bus.inj_req),
    .stat_sel(ctl_bus.stat_sel), .framer_state_word(ctl_bus.framer_state_word),
    .lane_align_state(ctl_bus.lane_align_state), .sync_input_used(ctl_bus.sync_input_used),
    .sync_input_choice(ctl_bus.sync_input_choice)
  );

  // free-running bus clock
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  task automatic close_out();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int w;
    w = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      w++;
    end while (pready !== 1'b1 && w < 50);
    if (w >= 50) errors++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x,
                        input logic xerr);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r & m, x);
    chk({31'h0, e}, {31'h0, xerr});
  endtask

  task automatic st_chk(input logic [1:0] f, input logic [31:0] m, input logic [31:0] x);
    wr(REG_STATUS, {30'h0, f});
    rd_chk(REG_STATUS, m, x, 1'b0);
  endtask

  task automatic pulse();
    @(posedge pclk);
    sysref_pin <= 1'b1;
    repeat (4) @(posedge pclk);
    sysref_pin <= 1'b0;
    repeat (8) @(posedge pclk);
  endtask

  task automatic wait_mf(input int f, output int c);
    c = 0;
    do begin
      @(posedge pclk);
      c++;
    end while (mf_start[f] !== 1'b1 && c < 100);
  endtask

  // lanes of one framer over ten cycles; counts cycles with lane 0 inverted
  task automatic watch(input int f, input logic [3:0] m, input logic [15:0] w,
                       input logic [15:0] step, output int c);
    logic [15:0] v;
    logic [15:0] e;
    logic        hit;
    c = 0;
    repeat (10) begin
      @(posedge pclk);
      hit = (lane_out[f*64 +: 16] === ~w);
      if (hit) c++;
      for (int l = 0; l < 4; l++) begin
        v = lane_out[(f*4+l)*16 +: 16];
        e = w + step * l[15:0];
        chk({16'h0, v}, {16'h0, (hit && m[l]) ? ~e : e});
      end
    end
  endtask

  // cuts a hung run short
  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    close_out();
  end

  initial begin
    errors = 0;
    n_checks = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    sysref_pin = 1'b0;
    sync_request_input = 3'b100;
    cfg_unsupported = 3'b010;
    for (int i = 0; i < 12; i++) sample_in[i*16 +: 16] = 16'hC300 + i[15:0];
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(REG_ENABLE, 32'h7, 32'h7, 1'b0);
    rd_chk(8'h3C, 32'hFFFFFFFF, 32'h0, 1'b1);
    chk({16'h0, lane_out[15:0]}, 32'hC300);
    wr(REG_SYNCSEL, 32'h8);
    st_chk(2'h1, 32'h000307FF, 32'h00020409);
    sync_request_input <= 3'b000;
    st_chk(2'h1, 32'h8, 32'h0);
    st_chk(2'h0, 32'h000307FF, 32'h200);
    // sysref held off until the sync sequence is done
    pulse();
    st_chk(2'h1, 32'h2, 32'h0);
    wr(REG_MCS, 32'h1);
    wr(REG_GATE, 32'h1);
    pulse();
    st_chk(2'h0, 32'h2, 32'h0);
    st_chk(2'h1, 32'h6, 32'h2);
    st_chk(2'h2, 32'h6, 32'h2);
    wait_mf(1, n);
    wait_mf(1, n);
    chk(n, 32);
    wr(REG_GATE, 32'h107);
    wait_mf(1, n);
    repeat (10) @(posedge pclk);
    pulse();
    st_chk(2'h0, 32'h6, 32'h2);
    st_chk(2'h1, 32'h6, 32'h6);
    wr(REG_ENABLE, 32'h5);
    st_chk(2'h1, 32'h104, 32'h100);
    wr(REG_ENABLE, 32'h7);
    rd_chk(REG_ENABLE, 32'h7, 32'h7, 1'b0);
    // user word repeated on framer 0, then corrupted once
    wr(REG_USER, 32'h1234);
    wr(REG_TEST, 32'h0901);
    repeat (6) @(posedge pclk);
    chk({16'h0, lane_out[15:0]}, 32'h1234);
    chk({16'h0, lane_out[64 +: 16]}, 32'hC304);
    wr(REG_INJECT, 32'h0500);
    watch(0, 4'h5, 16'h1234, 16'h0, n);
    chk(n, 1);
    wr(REG_INJECT, 32'h0F01);
    watch(1, 4'hF, 16'hC304, 16'h1, n);
    chk(n, 0);
    wr(REG_TEST, 32'h0A01);
    repeat (12) @(posedge pclk);
    chk({16'h0, lane_out[15:0]}, 32'h0);
    // every test source and insert point on framer 2
    for (int s = 1; s < 11; s++) begin
      wr(REG_TEST, 32'(32'h4 + (s << 8) + ((s % 3) << 16)));
      repeat (6) @(posedge pclk);
      chk({30'h0, insert_point_out[5:4]}, 32'(s % 3));
      chk({31'h0, lane_out[128 +: 16] !== 16'hC308}, 32'h1);
    end
    wr(REG_TEST, 32'h4);
    repeat (6) @(posedge pclk);
    chk({16'h0, lane_out[128 +: 16]}, 32'hC308);
    close_out();
  end
endmodule
